/* drpl_ref_select.sv */
// Reference priority selection and lock declaration with an AXI4-Lite register slave
`timescale 1ns/1ps
module drpl_ref_select
#(
    parameter int NUM_REFS = 10,
    parameter int ADDR_W = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_REFS-1:0] ref_qualified,
    input wire logic phase_valid,
    input wire logic [7:0] phase_err_code,
    output logic [3:0] sel_ref,
    output logic sel_valid,
    output logic dpll_locked
);
    localparam int NPAIR = (NUM_REFS + 1) / 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] rank_ff [NPAIR];
    logic [7:0] win_ff;
    logic [7:0] per_ff;
    logic [7:0] ctrl_ff;
    logic [3:0] sel_ff;
    logic valid_ff;
    logic lock_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Priority of reference i: even refs in the low nibble, odd in the high
    function automatic logic [3:0] prio_of(input logic [7:0] pair, input int i);
        prio_of = i[0] ? pair[7:4] : pair[3:0];
    endfunction

    // Map a byte address to a register slot; 4'hF means unmapped
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
        logic [13:0] idx;
        idx = 14'(addr >> 2);
        decode = 4'hF;
        if (addr[1:0] == 2'b00)
        begin
            for (int p = 0; p < NPAIR; p++)
            begin
                if (idx == drpl_pkg::IDX_RANK_A + 14'(p))
                begin
                    decode = 4'(p);
                end
            end
            if (idx == drpl_pkg::IDX_LOCK_WIN)
                decode = 4'h8;
            if (idx == drpl_pkg::IDX_LOCK_PER)
                decode = 4'h9;
            if (idx == drpl_pkg::IDX_SEL_CTRL)
                decode = 4'hA;
            if (idx == drpl_pkg::IDX_SEL_STAT)
                decode = 4'hB;
        end
    endfunction

    // Ten-power multiplier for the decade of a log code
    function automatic logic [33:0] decade(input logic [2:0] d);
        case (d)
            3'd0: decade = 34'd1;
            3'd1: decade = 34'd10;
            3'd2: decade = 34'd100;
            3'd3: decade = 34'd1000;
            3'd4: decade = 34'd10000;
            3'd5: decade = 34'd100000;
            default: decade = 34'd1000000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data taken in either order
    logic [3:0] wslot;
    logic do_write;
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign wslot = decode(awaddr_ff);
    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= drpl_pkg::RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb0_ff <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                // Status word is read-only, so a write to it is refused too
                bresp_ff <= (wslot > 4'hA) ? drpl_pkg::RESP_SLVERR : drpl_pkg::RESP_OKAY;
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration registers; only byte lane 0 carries data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rank_ff[0] <= drpl_pkg::RST_RANK_A;
            rank_ff[1] <= drpl_pkg::RST_RANK_B;
            rank_ff[2] <= drpl_pkg::RST_RANK_C;
            rank_ff[3] <= drpl_pkg::RST_RANK_D;
            rank_ff[4] <= drpl_pkg::RST_RANK_E;
            win_ff <= drpl_pkg::RST_LOCK_WIN;
            per_ff <= drpl_pkg::RST_LOCK_PER;
            ctrl_ff <= drpl_pkg::RST_SEL_CTRL;
        end
        else if (do_write && wstrb0_ff)
        begin
            // Codes outside the documented span are stored as written; the
            // period code is clipped at PER_MAX rather than policing software
            case (wslot)
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4: rank_ff[wslot[2:0]] <= wdata_ff[7:0];
                4'h8: win_ff <= wdata_ff[7:0];
                4'h9: per_ff <= wdata_ff[7:0];
                4'hA: ctrl_ff <= wdata_ff[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one cycle from address to data
    logic [3:0] rslot;
    logic [7:0] rbyte;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rslot = decode(s_axi_araddr);

    always_comb
    begin
        case (rslot)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: rbyte = rank_ff[rslot[2:0]];
            4'h8: rbyte = win_ff;
            4'h9: rbyte = per_ff;
            4'hA: rbyte = ctrl_ff;
            4'hB: rbyte = {2'b00, lock_ff, valid_ff, sel_ff};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= drpl_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rbyte};
            rresp_ff <= (rslot == 4'hF) ? drpl_pkg::RESP_SLVERR : drpl_pkg::RESP_OKAY;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Best qualified reference: strict compare keeps the lowest index on ties
    logic [3:0] best_code;
    logic [3:0] best_idx;
    logic found;
    logic [3:0] cur_code;
    logic keep;
    logic [3:0] man_ref;
    logic [3:0] nxt_sel;
    logic nxt_valid;

    always_comb
    begin
        best_code = drpl_pkg::PRIO_OFF;
        best_idx = 4'h0;
        found = 1'b0;
        for (int i = 0; i < NUM_REFS; i++)
        begin
            // Code 1111 never enters the race smaller code wins
            if (ref_qualified[i] && prio_of(rank_ff[i/2], i) != drpl_pkg::PRIO_OFF
                && prio_of(rank_ff[i/2], i) < best_code)
            begin
                best_code = prio_of(rank_ff[i/2], i);
                best_idx = 4'(i);
                found = 1'b1;
            end
        end
    end

    // Current reference stays when still qualified and no better rank exists
    assign cur_code = prio_of(rank_ff[sel_ff[3:1]], int'(sel_ff));
    // A disabled current code must not match an empty race, hence found
    assign keep = valid_ff && found && ref_qualified[sel_ff] && cur_code == best_code;
    assign man_ref = ctrl_ff[drpl_pkg::CTRL_MAN_LSB +: 4];

    always_comb
    begin
        nxt_sel = sel_ff;
        nxt_valid = 1'b0;
        if (!ctrl_ff[drpl_pkg::CTRL_AUTO_BIT])
        begin
            // Manual mode tracks the forced input whenever it is qualified
            if (man_ref < 4'(NUM_REFS))
            begin
                nxt_sel = man_ref;
                nxt_valid = ref_qualified[man_ref];
            end
        end
        else if (keep)
        begin
            nxt_valid = 1'b1;
        end
        else if (found)
        begin
            nxt_sel = best_idx;
            nxt_valid = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_ff <= 4'h0;
            valid_ff <= 1'b0;
        end
        else
        begin
            sel_ff <= nxt_sel;
            valid_ff <= nxt_valid;
        end
    end
    assign sel_ref = sel_ff;
    assign sel_valid = valid_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Lock observation: period in microseconds is mantissa times decade
    localparam logic [13:0] MANT [drpl_pkg::LOG_STEPS] = '{
        14'd1000, 14'd1075, 14'd1155, 14'd1241, 14'd1334, 14'd1433, 14'd1540, 14'd1655,
        14'd1778, 14'd1911, 14'd2054, 14'd2207, 14'd2371, 14'd2548, 14'd2738, 14'd2943,
        14'd3162, 14'd3398, 14'd3652, 14'd3924, 14'd4217, 14'd4532, 14'd4870, 14'd5233,
        14'd5623, 14'd6043, 14'd6494, 14'd6978, 14'd7499, 14'd8058, 14'd8660, 14'd9306};
    logic [6:0] tick_cnt_ff;
    logic tick;
    logic [33:0] obs_cnt_ff;
    logic [33:0] obs_limit;
    logic [3:0] prev_sel_ff;
    logic restart;
    logic [7:0] per_clip;

    // A code above the span is clipped so the period stays at the one for PER_MAX
    assign per_clip = (per_ff > drpl_pkg::PER_MAX) ? drpl_pkg::PER_MAX : per_ff;
    assign obs_limit = 34'(34'(MANT[per_clip[4:0]]) * decade(per_clip[7:5]));
    assign tick = tick_cnt_ff == 7'(drpl_pkg::TICK_CYCLES - 1);
    // Window exceeded or reference changed: the whole period starts again
    assign restart = !valid_ff || sel_ff != prev_sel_ff
        || (phase_valid && phase_err_code > win_ff);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tick_cnt_ff <= 7'd0;
        else
            tick_cnt_ff <= tick ? 7'd0 : tick_cnt_ff + 7'd1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            obs_cnt_ff <= '0;
            lock_ff <= 1'b0;
            prev_sel_ff <= 4'h0;
        end
        else
        begin
            prev_sel_ff <= sel_ff;
            if (restart)
            begin
                obs_cnt_ff <= '0;
                lock_ff <= 1'b0;
            end
            else if (obs_cnt_ff >= obs_limit)
            begin
                lock_ff <= 1'b1;
            end
            else if (tick)
            begin
                obs_cnt_ff <= obs_cnt_ff + 34'd1;
            end
        end
    end
    assign dpll_locked = lock_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // A rewrite to 1111 may leave the old choice standing for one cycle only
    a_off_never_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        valid_ff && ctrl_ff[0] && cur_code == drpl_pkg::PRIO_OFF
        |=> !valid_ff || sel_ff != $past(sel_ff))
        else $error("Disabled reference is selected");
    a_better_takes: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_ff[0] && found && (!valid_ff || best_code < cur_code) |=> sel_ff == $past(best_idx))
        else $error("Better reference not taken");
    a_equal_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_ff[0] && keep |=> sel_ff == $past(sel_ff) && valid_ff)
        else $error("Equal rank displaced selection");
    a_rank_order: assert property (@(posedge aclk) disable iff (!aresetn)
        found |-> best_code <= drpl_pkg::PRIO_WORST)
        else $error("Winning code outside ranked span");
    a_hold_none: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_ff[0] && !found |=> !valid_ff)
        else $error("Selection valid with nothing qualified");
    a_win_reset: assert property (@(posedge aclk)
        !aresetn |=> win_ff == 8'h92 && per_ff == 8'h80)
        else $error("Lock thresholds wrong after reset");
    a_lock_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        phase_valid && phase_err_code > win_ff |=> !lock_ff && obs_cnt_ff == 34'd0)
        else $error("Lock held past window excess");
    a_lock_needs: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(lock_ff) |-> $past(obs_cnt_ff) >= $past(obs_limit) && valid_ff)
        else $error("Lock declared before period elapsed");
    a_pair_map: assert property (@(posedge aclk) disable iff (!aresetn)
        found && best_idx == 4'd3 |-> best_code == rank_ff[1][7:4])
        else $error("Priority nibble mapping wrong");
    a_rank_used: assert property (@(posedge aclk) disable iff (!aresetn)
        found |-> ref_qualified[best_idx]
        && prio_of(rank_ff[best_idx[3:1]], int'(best_idx)) == best_code)
        else $error("Best reference not ranked by its own field");
    a_bresp_next: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("Write response missing");
endmodule

/* drpl_pkg.sv */
// Package for the reference priority and lock configuration block
package drpl_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [13:0] IDX_RANK_A = 14'h0615;
    localparam logic [13:0] IDX_RANK_B = 14'h0616;
    localparam logic [13:0] IDX_RANK_C = 14'h0617;
    localparam logic [13:0] IDX_RANK_D = 14'h0618;
    localparam logic [13:0] IDX_RANK_E = 14'h0619;
    localparam logic [13:0] IDX_LOCK_WIN = 14'h061D;
    localparam logic [13:0] IDX_LOCK_PER = 14'h061E;
    localparam logic [13:0] IDX_SEL_CTRL = 14'h0630;
    localparam logic [13:0] IDX_SEL_STAT = 14'h0631;
    // Reset values
    localparam logic [7:0] RST_RANK_A = 8'h10;
    localparam logic [7:0] RST_RANK_B = 8'h32;
    localparam logic [7:0] RST_RANK_C = 8'h54;
    localparam logic [7:0] RST_RANK_D = 8'h76;
    localparam logic [7:0] RST_RANK_E = 8'h98;
    localparam logic [7:0] RST_LOCK_WIN = 8'h92;
    localparam logic [7:0] RST_LOCK_PER = 8'h80;
    localparam logic [7:0] RST_SEL_CTRL = 8'h01;
    // Field positions
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_MAN_LSB = 4;
    localparam int STAT_VALID_BIT = 4;
    localparam int STAT_LOCK_BIT = 5;
    // Priority codes
    localparam logic [3:0] PRIO_BEST = 4'h0;
    localparam logic [3:0] PRIO_WORST = 4'hE;
    localparam logic [3:0] PRIO_OFF = 4'hF;
    // Log-encoded spans
    localparam logic [7:0] WIN_MAX = 8'hA0;
    localparam logic [7:0] PER_MIN = 8'h56;
    localparam logic [7:0] PER_MAX = 8'hC0;
    localparam int LOG_STEPS = 32;
    // Time base for the observation counter
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_NS / 1000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* drpl_ref_select_bench.sv */
// Self-checking bench for the reference priority and lock configuration block
`timescale 1ns/1ps
module drpl_ref_select_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] ref_qualified;
    logic phase_valid;
    logic [7:0] phase_err_code;
    logic [3:0] sel_ref;
    logic sel_valid, dpll_locked;
    int fails = 0;
    int cmp_count = 0;
    // Behavioural selection model: codes, qualified set, current choice
    int prio[10];
    logic [9:0] qual;
    int cur = 0;
    int curv = 0;
    logic [13:0] rst_idx[7] = '{drpl_pkg::IDX_RANK_A, drpl_pkg::IDX_RANK_B,
        drpl_pkg::IDX_RANK_C, drpl_pkg::IDX_RANK_D, drpl_pkg::IDX_RANK_E,
        drpl_pkg::IDX_LOCK_WIN, drpl_pkg::IDX_LOCK_PER};
    logic [7:0] rst_val[7] = '{8'h10, 8'h32, 8'h54, 8'h76, 8'h98, 8'h92, 8'h80};
    logic [13:0] bnd_idx[4] = '{drpl_pkg::IDX_LOCK_WIN, drpl_pkg::IDX_LOCK_WIN,
        drpl_pkg::IDX_LOCK_PER, drpl_pkg::IDX_LOCK_PER};
    logic [7:0] bnd_val[4] = '{8'h00, 8'ha0, 8'h56, 8'hc0};

    drpl_ref_select #(.NUM_REFS(10), .ADDR_W(16)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ref_qualified(ref_qualified), .phase_valid(phase_valid),
        .phase_err_code(phase_err_code), .sel_ref(sel_ref), .sel_valid(sel_valid),
        .dpll_locked(dpll_locked));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz
    always #5 aclk = ~aclk;

    // Every input has a value from time zero
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        ref_qualified = '0;
        phase_valid = 1'b0;
        phase_err_code = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic axi_write(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= 32'(d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 50)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        // Bready stays high so a following call never re-assigns it in one step
        chk(32'(s_axi_bvalid), 32'h0000_0001, "write answer");
        chk(32'(s_axi_bresp), 32'(er), "write response");
    endtask

    // Read: arvalid stays high until arready is sampled; rready stays high throughout
    task automatic axi_read(input logic [13:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (!s_axi_arready && n < 50);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        chk(32'(s_axi_rvalid), 32'h0000_0001, "read answer");
        chk(s_axi_rdata, 32'(ed), "read data");
        chk(32'(s_axi_rresp), 32'(er), "read response");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Model: best non-disabled code wins; an equal-ranked current choice is kept
    task automatic model_step();
        int best;
        best = 16;
        for (int i = 0; i < 10; i++)
            if (qual[i] && prio[i] != 15 && prio[i] < best)
                best = prio[i];
        if (best == 16)
            curv = 0;
        else if (!(curv != 0 && qual[cur] && prio[cur] == best))
        begin
            curv = 1;
            for (int i = 9; i >= 0; i--)
                if (qual[i] && prio[i] == best)
                    cur = i;
        end
    endtask

    // Apply a qualified set with random phase reports, then compare ports and status
    task automatic step(input logic [9:0] v);
        ref_qualified <= v;
        phase_valid <= 1'($urandom);
        phase_err_code <= 8'($urandom);
        qual = v;
        model_step();
        repeat (3) @(posedge aclk);
        chk(32'(sel_valid), 32'(curv), "selection valid");
        chk(32'(sel_ref), 32'(cur), "selected reference");
        chk(32'(dpll_locked), 32'h0000_0000, "lock before period");
        axi_read(drpl_pkg::IDX_SEL_STAT, {3'b000, 1'(curv), 4'(cur)}, 2'b00);
    endtask

    // Program all ten codes, two per byte, and read them back
    task automatic load_prio();
        logic [7:0] b;
        for (int p = 0; p < 5; p++)
        begin
            b = {4'(prio[2 * p + 1]), 4'(prio[2 * p])};
            axi_write(drpl_pkg::IDX_RANK_A + 14'(p), b, drpl_pkg::RESP_OKAY);
            axi_read(drpl_pkg::IDX_RANK_A + 14'(p), b, drpl_pkg::RESP_OKAY);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(32'h0000_a45e));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(sel_valid), 32'h0000_0000, "valid after reset");
        for (int i = 0; i < 7; i++)
            axi_read(rst_idx[i], rst_val[i], drpl_pkg::RESP_OKAY);
        // Unmapped place and the read-only status byte refuse writes
        axi_read(14'h0600, 8'h00, drpl_pkg::RESP_SLVERR);
        axi_write(14'h0600, 8'h5a, drpl_pkg::RESP_SLVERR);
        axi_write(drpl_pkg::IDX_SEL_STAT, 8'h3f, drpl_pkg::RESP_SLVERR);
        // Ends of the documented log-code spans are stored as written
        for (int i = 0; i < 4; i++)
        begin
            axi_write(bnd_idx[i], bnd_val[i], drpl_pkg::RESP_OKAY);
            axi_read(bnd_idx[i], bnd_val[i], drpl_pkg::RESP_OKAY);
        end
        // A write without byte lane 0 is answered but leaves the window alone
        s_axi_wstrb <= 4'h0;
        axi_write(drpl_pkg::IDX_LOCK_WIN, 8'h11, drpl_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axi_read(drpl_pkg::IDX_LOCK_WIN, 8'ha0, drpl_pkg::RESP_OKAY);
        // One best reference and three equal ones: revert to the best, keep among equals
        prio = '{0, 1, 1, 1, 15, 15, 15, 15, 15, 15};
        load_prio();
        step(10'h008);
        step(10'h00c);
        step(10'h00f);
        step(10'h00e);
        step(10'h002);
        // Disabling the selected input drops it even with nothing else qualified
        prio[1] = 15;
        load_prio();
        step(10'h002);
        step(10'h3f0);
        step(10'h000);
        // Random codes from a small set so ties and disabled inputs are common
        for (int r = 0; r < 6; r++)
        begin
            step(10'h000);
            for (int i = 0; i < 10; i++)
                prio[i] = ($urandom % 4 == 3) ? 15 : int'($urandom % 3);
            load_prio();
            for (int s = 0; s < 12; s++)
                step(10'($urandom));
        end
        // Manual mode bypasses the ranking and follows the forced index
        axi_write(drpl_pkg::IDX_SEL_CTRL, 8'h30, drpl_pkg::RESP_OKAY);
        ref_qualified <= 10'h008;
        repeat (3) @(posedge aclk);
        chk(32'({sel_valid, sel_ref}), 32'h0000_0013, "manual selection");
        axi_read(drpl_pkg::IDX_SEL_CTRL, 8'h30, drpl_pkg::RESP_OKAY);
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (30000) @(posedge aclk);
        fails++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        summarize();
    end
endmodule
